// ==== hw/rsc_pkg.sv ====
// Purpose: constants and helpers for the radio settings control block
// Assumes: 125 MHz mclk, frequencies in units of 100 Hz
// Notes: variant codes select the band plan
package rsc_pkg;
    localparam int CLK_MHZ = 125;
    localparam int CYC_PER_US = CLK_MHZ;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int CFG_PROMPT_US = 1700;
    localparam int CHAN_DLY_MS_433 = 47;
    localparam int CHAN_DLY_MS_868 = 43;
    localparam int CHAN_DLY_MS_915 = 70;
    localparam int MEM_WRITE_MS = 66;
    localparam int CFG_PROMPT_CYC = CFG_PROMPT_US * CYC_PER_US;
    localparam int MEM_WRITE_CYC = MEM_WRITE_MS * CYC_PER_MS;

    typedef enum logic [1:0] {
        VAR_433 = 2'h0,
        VAR_868 = 2'h1,
        VAR_915 = 2'h2
    } rsc_variant_t;

    typedef enum logic [3:0] {
        M_IDLE = 4'b0001,
        M_RX = 4'b0010,
        M_TX = 4'b0100,
        M_CFG = 4'b1000
    } rsc_mode_t;

    localparam logic [5:0] A_CHAN = 6'h00;
    localparam logic [5:0] A_LEVEL = 6'h04;
    localparam logic [5:0] A_MEM_CHAN = 6'h08;
    localparam logic [5:0] A_MEM_LEVEL = 6'h0C;
    localparam logic [5:0] A_MEM_RATE = 6'h10;
    localparam logic [5:0] A_TEST = 6'h14;
    localparam logic [5:0] A_RSSI = 6'h18;
    localparam logic [5:0] A_STATUS = 6'h1C;
    localparam logic [5:0] A_RATE = 6'h20;

    localparam logic [7:0] PROMPT_CHAR = 8'h3E;
    localparam logic [7:0] TEST_CONT_TX = 8'h32;
    localparam logic [6:0] CH_FIRST = 7'h01;
    localparam logic [6:0] CH_EXC = 7'h2F;
    localparam logic [23:0] F_EXC = 24'h8D_3C40;
    localparam logic [2:0] LVL_MIN = 3'h1;
    localparam logic [2:0] LVL_MAX = 3'h5;
    localparam logic [2:0] LVL_DFLT = 3'h5;
    localparam logic [2:0] RATE_MIN = 3'h3;
    localparam logic [2:0] RATE_MAX = 3'h5;
    localparam logic [2:0] RATE_DFLT = 3'h3;

    function automatic logic [6:0] max_chan(input logic [1:0] v);
        case (v)
            VAR_433: return 7'h45;
            VAR_868: return 7'h50;
            default: return 7'h33;
        endcase
    endfunction

    function automatic logic [6:0] dflt_chan(input logic [1:0] v);
        case (v)
            VAR_433: return 7'h36;
            VAR_868: return 7'h29;
            default: return 7'h1A;
        endcase
    endfunction

    function automatic int chan_dly_ms(input logic [1:0] v);
        case (v)
            VAR_433: return CHAN_DLY_MS_433;
            VAR_868: return CHAN_DLY_MS_868;
            default: return CHAN_DLY_MS_915;
        endcase
    endfunction

    function automatic logic [23:0] freq_of(input logic [1:0] v, input logic [6:0] n);
        logic [23:0] k;
        k = {17'h0_0000, n - CH_FIRST};
        case (v)
            VAR_433: return 24'h42_1517 + 24'(k * 24'h00_00FA);
            VAR_868: return 24'h84_72BD + 24'(k * 24'h00_00FA);
            default: return (n == CH_EXC) ? F_EXC : 24'h89_B5E8 + 24'(k * 24'h00_1388);
        endcase
    endfunction

    function automatic logic chan_ok(input logic [1:0] v, input logic [7:0] n);
        return (n >= {1'b0, CH_FIRST}) && (n <= {1'b0, max_chan(v)});
    endfunction

    function automatic logic lvl_ok(input logic [7:0] n);
        return (n >= {5'h00, LVL_MIN}) && (n <= {5'h00, LVL_MAX});
    endfunction

    function automatic logic rate_ok(input logic [1:0] v, input logic [7:0] n);
        return (v == VAR_915) && (n >= {5'h00, RATE_MIN}) && (n <= {5'h00, RATE_MAX});
    endfunction
endpackage

// ==== hw/rsc_radio_settings.sv ====
// Purpose: channel, level and rate control of a narrow-band radio module
// Assumes: rx_detect, tx_request, rssi_in come from logic on mclk
// Notes: por_n resets the stored defaults; resetn reloads the active settings from them
// Contract
// RULE_01 - 433 band: channels 1-69, 25 kHz steps
// RULE_02 - 868 band: channels 1-80, 25 kHz steps
// RULE_03 - 915 band: channels 1-51, 0.5 MHz, 47 special
// RULE_04 - factory channel 54, 41 or 26
// RULE_05 - five power indices, factory index 5
// RULE_06 - rate fixed, or 915 indices 3-5
// RULE_07 - channel and level commands change active values
// RULE_08 - rate changes only through memory write
// RULE_09 - memory write stores default channel and level
// RULE_10 - reset loads stored defaults as active settings
// RULE_11 - amplifier enables are active-high outputs
// RULE_12 - transmit enable exactly during transmit mode
// RULE_13 - low-noise enable during receive and idle
// RULE_14 - strength query returns one byte
// RULE_15 - prompt byte follows strength byte directly
// RULE_16 - host queries while the packet is arriving
// RULE_17 - test code 2 starts continuous transmission
// RULE_18 - strength value rises with input power
// RULE_19 - prompt 1.7 ms after setup pin low
// RULE_20 - channel command prompts after band delay
// RULE_21 - memory write busy 66 ms, then prompt
// RULE_22 - out-of-range values are ignored
// RULE_23 - both amplifier enables never high together
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rsc_radio_settings #(
    parameter rsc_pkg::rsc_variant_t VARIANT = rsc_pkg::VAR_433,
    parameter int unsigned CFG_PROMPT_CYCLES = rsc_pkg::CFG_PROMPT_CYC,
    parameter int unsigned CHAN_DELAY_CYCLES = rsc_pkg::chan_dly_ms(VARIANT) * rsc_pkg::CYC_PER_MS,
    parameter int unsigned MEM_WRITE_CYCLES = rsc_pkg::MEM_WRITE_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic por_n,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic setup_n_pin,
    input wire logic rx_detect,
    input wire logic tx_request,
    input wire logic [7:0] rssi_in,
    output logic [23:0] carrier_freq,
    output logic [2:0] tx_level,
    output logic [2:0] air_rate,
    output logic tx_amp_enable,
    output logic low_noise_amp_enable,
    output logic resp_valid,
    output logic [7:0] resp_byte
);
    import rsc_pkg::*;

    logic [6:0] nv_chan_q;
    logic [2:0] nv_level_q;
    logic [2:0] nv_rate_q;
    logic [6:0] chan_q;
    logic load_q;
    logic cont_tx_q;
    logic s1_q, s2_q, s3_q;
    logic cfg_low_q;
    logic cfg_low_d1_q;
    logic [23:0] tmr_q;
    logic prompt_pend_q;
    logic rsp_pend_q;
    rsc_mode_t mode_q, mode_d;
    logic busy;
    logic wr_ok;
    logic rd_rssi;
    logic prompt_set;
    logic prompt_take;
    logic cfg_enter;
    logic cfg_wait_q;
    logic tmr_start;

    assign busy = (tmr_q != 24'h00_0000);
    assign wr_ok = reg_wr && !busy;
    assign rd_rssi = reg_rd && (reg_addr == A_RSSI);
    assign cfg_enter = cfg_low_q && !cfg_low_d1_q;
    assign tmr_start = wr_ok && (reg_addr == A_CHAN || reg_addr == A_MEM_CHAN ||
                                 reg_addr == A_MEM_LEVEL || reg_addr == A_MEM_RATE);
    assign prompt_take = !rsp_pend_q && !rd_rssi && prompt_pend_q;

    // stored defaults, kept across resetn
    always_ff @(posedge mclk or negedge por_n) begin
        if (!por_n) begin
            nv_chan_q <= dflt_chan(VARIANT); // RULE_04
            nv_level_q <= LVL_DFLT; // RULE_05
            nv_rate_q <= RATE_DFLT; // RULE_06
        end else if (wr_ok) begin
            case (reg_addr)
                A_MEM_CHAN: begin
                    if (chan_ok(VARIANT, reg_wdata)) begin
                        nv_chan_q <= reg_wdata[6:0]; // RULE_09
                    end
                end
                A_MEM_LEVEL: begin
                    if (lvl_ok(reg_wdata)) begin
                        nv_level_q <= reg_wdata[2:0]; // RULE_09
                    end
                end
                A_MEM_RATE: begin
                    if (rate_ok(VARIANT, reg_wdata)) begin
                        nv_rate_q <= reg_wdata[2:0]; // RULE_08
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // active settings
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            load_q <= 1'b1;
            chan_q <= dflt_chan(VARIANT);
            tx_level <= LVL_DFLT;
            air_rate <= RATE_DFLT;
        end else if (load_q) begin
            load_q <= 1'b0;
            chan_q <= nv_chan_q; // RULE_10
            tx_level <= nv_level_q; // RULE_10
            air_rate <= nv_rate_q; // RULE_08
        end else if (wr_ok && reg_addr == A_CHAN) begin
            if (chan_ok(VARIANT, reg_wdata)) begin // RULE_22
                chan_q <= reg_wdata[6:0]; // RULE_07
            end
        end else if (wr_ok && reg_addr == A_LEVEL) begin
            if (lvl_ok(reg_wdata)) begin // RULE_22
                tx_level <= reg_wdata[2:0]; // RULE_07
            end
        end
    end

    // carrier from channel number
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            carrier_freq <= 24'h00_0000;
        end else begin
            carrier_freq <= freq_of(VARIANT, chan_q); // RULE_01 RULE_02 RULE_03
        end
    end

    // continuous transmission test
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cont_tx_q <= 1'b0;
        end else if (wr_ok && reg_addr == A_TEST) begin
            cont_tx_q <= (reg_wdata == TEST_CONT_TX); // RULE_17
        end
    end

    // setup pin synchroniser and filter
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            cfg_low_q <= 1'b0;
            cfg_low_d1_q <= 1'b0;
        end else begin
            s1_q <= setup_n_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                cfg_low_q <= !s3_q;
            end
            cfg_low_d1_q <= cfg_low_q;
        end
    end

    // setup entry held until the timer is free
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cfg_wait_q <= 1'b0;
        end else begin
            cfg_wait_q <= (cfg_enter || cfg_wait_q) && (busy || tmr_start); // RULE_19
        end
    end

    // prompt delay timer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tmr_q <= 24'h00_0000;
        end else if (busy) begin
            tmr_q <= tmr_q - 24'h00_0001;
        end else if (wr_ok && reg_addr == A_CHAN) begin
            tmr_q <= 24'(CHAN_DELAY_CYCLES); // RULE_20
        end else if (wr_ok && (reg_addr == A_MEM_CHAN || reg_addr == A_MEM_LEVEL ||
                               reg_addr == A_MEM_RATE)) begin
            tmr_q <= 24'(MEM_WRITE_CYCLES); // RULE_21
        end else if (cfg_enter || cfg_wait_q) begin
            tmr_q <= 24'(CFG_PROMPT_CYCLES); // RULE_19
        end
    end

    always_comb begin
        prompt_set = 1'b0;
        if (tmr_q == 24'h00_0001) begin
            prompt_set = 1'b1; // RULE_19 RULE_20 RULE_21
        end else if (wr_ok && (reg_addr == A_LEVEL || reg_addr == A_TEST)) begin
            prompt_set = 1'b1;
        end
    end

    // pending prompt; a new prompt wins over the take
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prompt_pend_q <= 1'b0;
        end else begin
            prompt_pend_q <= (prompt_pend_q && !prompt_take) || prompt_set;
        end
    end

    // response byte stream
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            resp_valid <= 1'b0;
            resp_byte <= 8'h00;
            rsp_pend_q <= 1'b0;
        end else if (rsp_pend_q) begin
            resp_valid <= 1'b1;
            resp_byte <= PROMPT_CHAR; // RULE_15
            rsp_pend_q <= 1'b0;
        end else if (rd_rssi) begin
            resp_valid <= 1'b1;
            resp_byte <= rssi_in; // RULE_14 RULE_18
            rsp_pend_q <= 1'b1;
        end else if (prompt_take) begin
            resp_valid <= 1'b1;
            resp_byte <= PROMPT_CHAR;
        end else begin
            resp_valid <= 1'b0;
            resp_byte <= 8'h00;
        end
    end

    // operating mode
    always_comb begin
        if (cont_tx_q) begin
            mode_d = M_TX; // RULE_17
        end else if (cfg_low_q) begin
            mode_d = M_CFG;
        end else if (tx_request) begin
            mode_d = M_TX;
        end else if (rx_detect) begin
            mode_d = M_RX; // RULE_16
        end else begin
            mode_d = M_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= M_IDLE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // amplifier enables, registered together with the mode
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_amp_enable <= 1'b0;
            low_noise_amp_enable <= 1'b0;
        end else begin
            case (mode_d)
                M_TX: begin
                    tx_amp_enable <= 1'b1; // RULE_11 RULE_12 RULE_23
                    low_noise_amp_enable <= 1'b0;
                end
                M_RX, M_IDLE: begin
                    tx_amp_enable <= 1'b0;
                    low_noise_amp_enable <= 1'b1; // RULE_11 RULE_13 RULE_23
                end
                default: begin
                    tx_amp_enable <= 1'b0;
                    low_noise_amp_enable <= 1'b0;
                end
            endcase
        end
    end

    // register read data, one cycle after the strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                A_CHAN: reg_rdata <= {1'b0, chan_q};
                A_LEVEL: reg_rdata <= {5'h00, tx_level};
                A_MEM_CHAN: reg_rdata <= {1'b0, nv_chan_q};
                A_MEM_LEVEL: reg_rdata <= {5'h00, nv_level_q};
                A_MEM_RATE: reg_rdata <= {5'h00, nv_rate_q};
                A_TEST: reg_rdata <= {7'h00, cont_tx_q};
                A_RSSI: reg_rdata <= rssi_in;
                A_STATUS: reg_rdata <= {mode_q, prompt_pend_q, cfg_low_q, cont_tx_q, busy};
                A_RATE: reg_rdata <= {5'h00, air_rate};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // rsc_radio_settings
`default_nettype wire

// ==== sim/rsc_chk.sv ====
// Purpose: port assertions for the radio settings block
// Assumes: single mclk domain, resetn async active low
// Notes: attached by bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module rsc_chk #(
    parameter rsc_pkg::rsc_variant_t VARIANT = rsc_pkg::VAR_433
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] rssi_in,
    input wire logic [23:0] carrier_freq,
    input wire logic [2:0] tx_level,
    input wire logic [2:0] air_rate,
    input wire logic tx_amp_enable,
    input wire logic low_noise_amp_enable,
    input wire logic resp_valid,
    input wire logic [7:0] resp_byte
);
    import rsc_pkg::*;
    logic [7:0] rssi_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // strength seen at the query edge
    always_ff @(posedge mclk) begin
        rssi_q <= rssi_in;
    end
    sequence s_pair(logic [7:0] b);
        resp_valid && resp_byte == b ##1 resp_valid && resp_byte == PROMPT_CHAR;
    endsequence
    AST_AMP_EXCL: assert property (!(tx_amp_enable && low_noise_amp_enable))
        else $error("both amplifier enables high");
    AST_RSSI_PAIR: assert property (reg_rd && reg_addr == A_RSSI |=> s_pair(rssi_q))
        else $error("strength byte and prompt not adjacent");
    AST_RDATA_IDLE: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data without read");
    AST_LEVEL_RANGE: assert property (tx_level >= LVL_MIN && tx_level <= LVL_MAX)
        else $error("power index out of range");
    AST_RATE_FIXED: assert property (VARIANT != VAR_915 |-> air_rate == RATE_DFLT)
        else $error("rate not fixed");
    AST_LEVEL_BAD: assert property (reg_wr && reg_addr == A_LEVEL && (reg_wdata == 8'h00
        || reg_wdata > 8'h05) |=> $stable(tx_level))
        else $error("bad power index applied");
    AST_FREQ_GRID: assert property (VARIANT == VAR_433 && carrier_freq != 24'h00_0000
        |-> carrier_freq >= 24'h42_1517 && carrier_freq <= 24'h42_577F
        && (carrier_freq - 24'h42_1517) % 24'h00_00FA == 24'h00_0000)
        else $error("carrier off channel grid");
    AST_RESP_ZERO: assert property (!resp_valid |-> resp_byte == 8'h00)
        else $error("response byte without valid");
endmodule // rsc_chk
bind rsc_radio_settings rsc_chk #(.VARIANT(VARIANT)) rsc_chk_inst (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rssi_in(rssi_in),
    .carrier_freq(carrier_freq), .tx_level(tx_level), .air_rate(air_rate),
    .tx_amp_enable(tx_amp_enable), .low_noise_amp_enable(low_noise_amp_enable),
    .resp_valid(resp_valid), .resp_byte(resp_byte)
);
`default_nettype wire

// ==== sim/rsc_rf_side.sv ====
// Purpose: radio front end beside the settings block
// Assumes: levels change on mclk
// Notes: strength only meaningful while a packet arrives
`timescale 1ns/100ps
`default_nettype none
module rsc_rf_side (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic want_rx,
    input wire logic want_tx,
    input wire logic [7:0] power,
    output logic rx_detect,
    output logic tx_request,
    output logic [7:0] rssi_in
);
    // noise pattern outside packets
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_detect <= 1'b0;
            tx_request <= 1'b0;
            rssi_in <= 8'hA5;
        end else begin
            rx_detect <= want_rx;
            tx_request <= want_tx;
            rssi_in <= want_rx ? power : ~rssi_in;
        end
    end
endmodule // rsc_rf_side
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: directed test of the radio settings block
// Assumes: 433 band, second unit on 915 band, shortened delays
// Notes: bench acts as host on the register port
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import rsc_pkg::*;
    localparam int CFG_CYC = 20;
    localparam int CHAN_CYC = 30;
    localparam int MEM_CYC = 40;
    logic mclk, resetn, por_n, reg_wr, reg_rd, setup_n_pin, want_rx, want_tx;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, power, rssi_in, resp_byte, rd_q;
    logic rx_detect, tx_request, tx_amp_enable, low_noise_amp_enable, resp_valid;
    logic [23:0] carrier_freq;
    logic [2:0] tx_level, air_rate;
    logic [23:0] carrier_freq_b;
    logic [2:0] air_rate_b;
    int mismatches = 0;
    int num_checks = 0;
    int n;
    rsc_radio_settings #(.VARIANT(VAR_433), .CFG_PROMPT_CYCLES(CFG_CYC),
        .CHAN_DELAY_CYCLES(CHAN_CYC), .MEM_WRITE_CYCLES(MEM_CYC)) rsc_radio_settings_inst (
        .mclk(mclk), .resetn(resetn), .por_n(por_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .setup_n_pin(setup_n_pin), .rx_detect(rx_detect), .tx_request(tx_request),
        .rssi_in(rssi_in), .carrier_freq(carrier_freq), .tx_level(tx_level),
        .air_rate(air_rate), .tx_amp_enable(tx_amp_enable),
        .low_noise_amp_enable(low_noise_amp_enable), .resp_valid(resp_valid),
        .resp_byte(resp_byte));
    // 915 band unit on the same port, watched for its own band plan
    rsc_radio_settings #(.VARIANT(VAR_915), .CFG_PROMPT_CYCLES(CFG_CYC),
        .CHAN_DELAY_CYCLES(CHAN_CYC), .MEM_WRITE_CYCLES(MEM_CYC)) rsc_radio_settings_b_inst (
        .mclk(mclk), .resetn(resetn), .por_n(por_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
        .setup_n_pin(setup_n_pin), .rx_detect(rx_detect), .tx_request(tx_request),
        .rssi_in(rssi_in), .carrier_freq(carrier_freq_b), .tx_level(),
        .air_rate(air_rate_b), .tx_amp_enable(), .low_noise_amp_enable(),
        .resp_valid(), .resp_byte());
    rsc_rf_side rsc_rf_side_inst (.mclk(mclk), .resetn(resetn), .want_rx(want_rx),
        .want_tx(want_tx), .power(power), .rx_detect(rx_detect),
        .tx_request(tx_request), .rssi_in(rssi_in));
    function automatic logic [23:0] f433(input int ch);
        return 24'h42_1517 + 24'(ch - 1) * 24'h00_00FA;
    endfunction
    task stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [5:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask
    task wait_prompt(input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge mclk);
            #1;
            if (resp_valid === 1'b1 && resp_byte === PROMPT_CHAR) break;
        end
        if (n > lim) begin
            mismatches++;
            stop_test();
        end
    endtask
    task settle(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        resetn = 1'b0;
        por_n = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        setup_n_pin = 1'b1;
        want_rx = 1'b0;
        want_tx = 1'b0;
        power = 8'h00;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        por_n <= 1'b1;
        settle(3);
        chk(carrier_freq, f433(54));
        chk(tx_level, 5);
        chk(air_rate, 3);
        chk({tx_amp_enable, low_noise_amp_enable}, 2'b01);
        chk(carrier_freq_b, 24'h8B_9E30);
        chk(air_rate_b, 3);
        $display("test defaults done");
        wr(A_LEVEL, 8'h02);
        wait_prompt(8);
        chk(tx_level, 2);
        wr(A_LEVEL, 8'h06);
        wait_prompt(8);
        chk(tx_level, 2);
        wr(A_CHAN, 8'h45);
        wait_prompt(CHAN_CYC + 8);
        chk(n >= CHAN_CYC, 1);
        chk(carrier_freq, f433(69));
        wr(A_CHAN, 8'h46);
        wait_prompt(CHAN_CYC + 8);
        chk(carrier_freq, f433(69));
        wr(A_CHAN, 8'h2F);
        wait_prompt(CHAN_CYC + 8);
        chk(carrier_freq_b, F_EXC);
        chk(carrier_freq, f433(47));
        $display("test runtime settings done");
        want_tx <= 1'b1;
        settle(3);
        chk({tx_amp_enable, low_noise_amp_enable}, 2'b10);
        want_tx <= 1'b0;
        want_rx <= 1'b1;
        power <= 8'h20;
        settle(3);
        chk({tx_amp_enable, low_noise_amp_enable}, 2'b01);
        rd(A_RSSI);
        chk(resp_byte, 8'h20);
        settle(1);
        chk(resp_byte, PROMPT_CHAR);
        power <= 8'h60;
        settle(3);
        rd(A_RSSI);
        chk(rd_q > 8'h20, 1);
        settle(2);
        wr(A_TEST, TEST_CONT_TX);
        wait_prompt(8);
        chk({tx_amp_enable, low_noise_amp_enable}, 2'b10);
        wr(A_TEST, 8'h00);
        wait_prompt(8);
        want_rx <= 1'b0;
        $display("test modes done");
        wr(A_MEM_CHAN, 8'h01);
        wait_prompt(MEM_CYC + 8);
        chk(n >= MEM_CYC, 1);
        wr(A_MEM_LEVEL, 8'h03);
        wait_prompt(MEM_CYC + 8);
        wr(A_MEM_RATE, 8'h05);
        settle(MEM_CYC + 8);
        resetn <= 1'b0;
        settle(2);
        resetn <= 1'b1;
        settle(3);
        chk(carrier_freq, f433(1));
        chk(tx_level, 3);
        chk(air_rate, 3);
        chk(air_rate_b, 5);
        chk(carrier_freq_b, 24'h89_B5E8);
        rd(6'h3F);
        chk(rd_q, 8'h00);
        $display("test stored defaults done");
        setup_n_pin <= 1'b0;
        wait_prompt(CFG_CYC + 16);
        chk(n >= CFG_CYC, 1);
        chk({tx_amp_enable, low_noise_amp_enable}, 2'b00);
        setup_n_pin <= 1'b1;
        settle(8);
        $display("test setup pin done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
